// [include/pmevs_params.svh]
// offsets, field positions, reset values and timing counts of the pm event status block
`ifndef PMEVS_PARAMS_SVH
`define PMEVS_PARAMS_SVH

// register byte offsets
`define PMEVS_STS_OFS 4'h0
`define PMEVS_EN_OFS 4'h4
`define PMEVS_CTL_OFS 4'h8
`define PMEVS_TMR_OFS 4'hc

// status / enable bit positions
`define PMEVS_BIT_TMR 0
`define PMEVS_BIT_GBL 5
`define PMEVS_BIT_BTN 8
`define PMEVS_BIT_OVR 11

// control bit positions
`define PMEVS_BIT_SCISEL 0
`define PMEVS_BIT_RLS 2

// implemented bits of status and enable
`define PMEVS_STS_MASK 16'h0921

// reset values
`define PMEVS_EN_RST 16'h0000
`define PMEVS_EN_AFTER_OVR 16'h0100
`define PMEVS_SCISEL_RST 1'b0

// timer
`define PMEVS_TMR_W 24
`define PMEVS_TMR_FLAG_BIT 22
`define PMEVS_TMR_DIV 5'h1c

// sleep state codes
`define PMEVS_S0 3'h0
`define PMEVS_S1 3'h1
`define PMEVS_S5 3'h5

// override hold time
`define PMEVS_CLK_HZ 64'd100000000
`define PMEVS_OVR_TIME_S 64'd4
`define PMEVS_OVR_CYCLES (`PMEVS_OVR_TIME_S * `PMEVS_CLK_HZ)

`endif

// [include/pmevs_pkg.sv]
// types of the pm event status block
package pmevs_pkg;

	typedef enum logic [1:0] {
		PMEVS_OVR_IDLE = 2'b00,
		PMEVS_OVR_HELD = 2'b01,
		PMEVS_OVR_DONE = 2'b10
	} pmevs_ovr_state_t;

	typedef struct packed {
		logic ovr;
		logic btn;
		logic gbl;
		logic tmr;
	} pmevs_flags_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pmevs_avreq_t;

endpackage : pmevs_pkg

// [hw/pmevs_top.sv]
// power management event status, lower half, with avalon-mm register slave
// Function
// - button flag survives reset-port hard reset
// - button assertion sets flag, no enable needed
// - long hold: clear press, set override, S5
// - after override only button wake enabled
// - button flag clears on write one
// - S0: flag and enable raise SCI/SMI
// - S1-S5: flag and enable raise wake
// - firmware attention sets attention flag
// - firmware release raises SCI and flag
// - timer bit 22 rising sets overflow
// - overflow period fixed by timer clock
// - enabled overflow raises SCI or SMI
// - overflow flag clears on write one
// - override flag sticky, forces S5, W1C
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`include "pmevs_params.svh"

module pmevs_top
	import pmevs_pkg::*;
#(
	parameter logic [31:0] OVR_CYCLES = 32'(`PMEVS_OVR_CYCLES)
) (
	input wire logic i_ref_clk, // 100 MHz clock
	input wire logic i_rst, // async reset, active high
	input wire logic i_hard_rst, // reset-port hard reset, sync
	input wire logic i_power_button_in_n, // power button, low = pressed
	input wire logic [2:0] i_sleep_state, // 0 = S0, 1..5 = S1..S5
	input wire logic [3:0] i_address, // avalon byte address
	input wire logic i_read, // avalon read
	input wire logic i_write, // avalon write
	input wire logic [3:0] i_byteenable, // avalon byte enables
	input wire logic [31:0] i_writedata, // avalon write data
	output logic [31:0] o_readdata, // avalon read data
	output logic o_waitrequest, // avalon waitrequest
	output logic o_sci, // SCI level
	output logic o_system_mgmt_irq_n, // SMI, low active
	output logic o_wake, // wake event level
	output logic o_s5_request, // one-cycle S5 transition pulse
	output logic o_irq // unmasked status pending
);

	pmevs_avreq_t req;
	wire pmevs_flags_t flags_reg;
	pmevs_ovr_state_t ovr_state_reg;
	pmevs_ovr_state_t ovr_state_next;
	logic wait_reg;
	logic [31:0] readdata_reg;
	logic [15:0] en_reg;
	logic [15:0] en_next;
	logic sci_sel_reg;
	logic sci_sel_next;
	logic [31:0] ovr_cnt_reg;
	logic [31:0] ovr_cnt_next;
	logic btn_prev_reg;
	logic [4:0] div_reg;
	logic [`PMEVS_TMR_W-1:0] tmr_reg;
	logic [`PMEVS_TMR_W-1:0] tmr_next;
	logic sci_reg;
	logic smi_n_reg;
	logic wake_reg;
	logic s5_reg;
	logic irq_reg;

	assign req.read = i_read;
	assign req.write = i_write;
	assign req.addr = i_address;
	assign req.be = i_byteenable;
	assign req.wdata = i_writedata;

	// bus decode: answer one cycle after request, commit on the acknowledged edge
	wire req_any = req.read | req.write;
	wire take = req_any & wait_reg;
	wire commit = req_any & ~wait_reg;
	wire sel_sts = req.addr == `PMEVS_STS_OFS;
	wire sel_en = req.addr == `PMEVS_EN_OFS;
	wire sel_ctl = req.addr == `PMEVS_CTL_OFS;
	wire sel_tmr = req.addr == `PMEVS_TMR_OFS;
	wire wr_lo = commit & req.write & req.be[0];
	wire wr_hi = commit & req.write & req.be[1];
	wire [15:0] wr_lane = {(wr_hi ? req.wdata[15:8] : 8'h00), (wr_lo ? req.wdata[7:0] : 8'h00)};
	wire [15:0] lane_mask = {{8{wr_hi}}, {8{wr_lo}}};

	// write-one-to-clear strobes, reserved positions masked off
	wire [15:0] w1c = wr_lane & `PMEVS_STS_MASK & {16{sel_sts}};
	wire clr_tmr = w1c[`PMEVS_BIT_TMR];
	wire clr_gbl = w1c[`PMEVS_BIT_GBL];
	wire clr_btn = w1c[`PMEVS_BIT_BTN];
	wire clr_ovr = w1c[`PMEVS_BIT_OVR];

	// firmware release strobe, self clearing
	wire rls = wr_lo & sel_ctl & req.wdata[`PMEVS_BIT_RLS];

	// power button assertion edge
	wire btn_fall = btn_prev_reg & ~i_power_button_in_n;

	// override: fires once the pin has been low longer than the hold time
	wire ovr_fire = (ovr_state_reg == PMEVS_OVR_HELD) & ~i_power_button_in_n & (ovr_cnt_reg == OVR_CYCLES);

	// timer tick and bit 22 rising edge
	wire tick = div_reg == (`PMEVS_TMR_DIV - 5'h01);
	wire tmr_rise = tick & ~tmr_reg[`PMEVS_TMR_FLAG_BIT] & tmr_next[`PMEVS_TMR_FLAG_BIT];

	assign tmr_next = tmr_reg + `PMEVS_TMR_W'(1);

	always_comb begin
		ovr_state_next = ovr_state_reg;
		ovr_cnt_next = ovr_cnt_reg;
		case (ovr_state_reg)
			PMEVS_OVR_IDLE: begin
				ovr_cnt_next = 32'h00000000;
				if (!i_power_button_in_n) begin
					ovr_state_next = PMEVS_OVR_HELD;
				end
			end
			PMEVS_OVR_HELD: begin
				if (i_power_button_in_n) begin
					ovr_state_next = PMEVS_OVR_IDLE;
				end else if (ovr_fire) begin
					ovr_state_next = PMEVS_OVR_DONE;
				end else begin
					ovr_cnt_next = ovr_cnt_reg + 32'h00000001;
				end
			end
			PMEVS_OVR_DONE: begin
				if (i_power_button_in_n) begin
					ovr_state_next = PMEVS_OVR_IDLE;
				end
			end
			default: begin
				ovr_state_next = PMEVS_OVR_IDLE;
			end
		endcase
	end

	// sticky flags: a set in the same cycle as a clear wins
	pmevs_sticky #(
		.W(1)
	) sticky_tmr_i (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_set(tmr_rise),
		.i_clr(clr_tmr),
		.i_drop(i_hard_rst),
		.o_flag(flags_reg.tmr)
	);

	pmevs_sticky #(
		.W(1)
	) sticky_gbl_i (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_set(rls),
		.i_clr(clr_gbl),
		.i_drop(i_hard_rst),
		.o_flag(flags_reg.gbl)
	);

	// button flag ignores the hard reset, only the override drops it
	pmevs_sticky #(
		.W(1)
	) sticky_btn_i (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_set(btn_fall),
		.i_clr(clr_btn),
		.i_drop(ovr_fire),
		.o_flag(flags_reg.btn)
	);

	pmevs_sticky #(
		.W(1)
	) sticky_ovr_i (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_set(ovr_fire),
		.i_clr(clr_ovr),
		.i_drop(1'b0),
		.o_flag(flags_reg.ovr)
	);

	// enable / mask register and routing select
	always_comb begin
		en_next = en_reg;
		sci_sel_next = sci_sel_reg;
		if (sel_en) begin
			en_next = (en_reg & ~lane_mask) | (wr_lane & lane_mask & `PMEVS_STS_MASK);
		end
		if (sel_ctl & wr_lo) begin
			sci_sel_next = req.wdata[`PMEVS_BIT_SCISEL];
		end
		if (ovr_fire) begin
			en_next = `PMEVS_EN_AFTER_OVR;
		end
		if (i_hard_rst) begin
			en_next = `PMEVS_EN_RST;
			sci_sel_next = `PMEVS_SCISEL_RST;
		end
	end

	// event routing
	wire in_s0 = i_sleep_state == `PMEVS_S0;
	wire sleeping = (i_sleep_state >= `PMEVS_S1) & (i_sleep_state <= `PMEVS_S5);
	wire pend_tmr = flags_reg.tmr & en_reg[`PMEVS_BIT_TMR];
	wire pend_btn = flags_reg.btn & en_reg[`PMEVS_BIT_BTN];
	wire sci_d = in_s0 & sci_sel_reg & (pend_tmr | pend_btn | flags_reg.gbl);
	wire smi_d = in_s0 & ~sci_sel_reg & (pend_tmr | pend_btn);
	wire wake_d = sleeping & pend_btn;

	wire [15:0] sts_view = {4'h0, flags_reg.ovr, 2'b00, flags_reg.btn, 2'b00,
		flags_reg.gbl, 4'h0, flags_reg.tmr};
	wire irq_d = |(sts_view & en_reg);

	wire [31:0] rd_mux = sel_sts ? {16'h0000, sts_view} :
		sel_en ? {16'h0000, en_reg} :
		sel_ctl ? {31'h00000000, sci_sel_reg} :
		sel_tmr ? {8'h00, tmr_reg} : 32'h00000000;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_reg <= 1'b1;
			readdata_reg <= 32'h00000000;
		end else begin
			wait_reg <= ~take;
			if (take & req.read) begin
				readdata_reg <= rd_mux;
			end
		end
	end

	// override timing ignores the hard reset
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ovr_state_reg <= PMEVS_OVR_IDLE;
			ovr_cnt_reg <= 32'h00000000;
			btn_prev_reg <= 1'b1;
		end else begin
			ovr_state_reg <= ovr_state_next;
			ovr_cnt_reg <= ovr_cnt_next;
			btn_prev_reg <= i_power_button_in_n;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			en_reg <= `PMEVS_EN_RST;
			sci_sel_reg <= `PMEVS_SCISEL_RST;
		end else begin
			en_reg <= en_next;
			sci_sel_reg <= sci_sel_next;
		end
	end

	// free-running timer, ticking at the pm timer rate
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			div_reg <= 5'h00;
			tmr_reg <= '0;
		end else if (i_hard_rst) begin
			div_reg <= 5'h00;
			tmr_reg <= '0;
		end else begin
			div_reg <= tick ? 5'h00 : div_reg + 5'h01;
			if (tick) begin
				tmr_reg <= tmr_next;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sci_reg <= 1'b0;
			smi_n_reg <= 1'b1;
			wake_reg <= 1'b0;
			s5_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			sci_reg <= sci_d;
			smi_n_reg <= ~smi_d;
			wake_reg <= wake_d;
			s5_reg <= ovr_fire;
			irq_reg <= irq_d;
		end
	end

	assign o_readdata = readdata_reg;
	assign o_waitrequest = wait_reg;
	assign o_sci = sci_reg;
	assign o_system_mgmt_irq_n = smi_n_reg;
	assign o_wake = wake_reg;
	assign o_s5_request = s5_reg;
	assign o_irq = irq_reg;

endmodule : pmevs_top

// write-one-to-clear event flags: set beats clear, drop beats both
module pmevs_sticky
	import pmevs_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic i_ref_clk, // clock
	input wire logic i_rst, // async reset, active high
	input wire logic [W-1:0] i_set, // hardware events
	input wire logic [W-1:0] i_clr, // software writes of one
	input wire logic i_drop, // forced clear by hardware
	output logic [W-1:0] o_flag // sticky flags
);

	logic [W-1:0] flag_reg;
	logic [W-1:0] flag_next;

	assign flag_next = ((flag_reg & ~i_clr) | i_set) & ~{W{i_drop}};

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign o_flag = flag_reg;

endmodule : pmevs_sticky

// [sim/pmevs_sva.sv]
// port assertions of the pm event status block
module pmevs_sva #(
	parameter logic [31:0] OVR_CYCLES = 32'd20
) (
	input wire logic i_ref_clk, // clock
	input wire logic i_rst, // reset
	input wire logic i_power_button_in_n, // button pin
	input wire logic [2:0] i_sleep_state, // sleep state
	input wire logic [3:0] i_address, // address
	input wire logic i_read, // read
	input wire logic [31:0] o_readdata, // read data
	input wire logic o_waitrequest, // wait
	input wire logic o_sci, // sci
	input wire logic o_system_mgmt_irq_n, // smi
	input wire logic o_wake, // wake
	input wire logic o_s5_request // s5 pulse
);
	logic [31:0] low_cnt_reg;
	logic rd_done;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	assign rd_done = i_read && !o_waitrequest;
	// consecutive low cycles of the pin
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) low_cnt_reg <= 32'h0;
		else low_cnt_reg <= i_power_button_in_n ? 32'h0 : low_cnt_reg + 32'h1;
	end
	sequence s_long_hold;
		$past(low_cnt_reg) >= OVR_CYCLES;
	endsequence
	a_wait_answer: assert property (i_read && o_waitrequest |=> !o_waitrequest) else $error("no answer");
	a_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest) else $error("wait low too long");
	a_sci_awake: assert property (o_sci |-> $past(i_sleep_state) == 3'h0) else $error("sci asleep");
	a_smi_awake: assert property (!o_system_mgmt_irq_n |-> $past(i_sleep_state) == 3'h0 && !o_sci)
		else $error("smi asleep");
	a_wake_sleep: assert property (o_wake |-> $past(i_sleep_state) inside {[3'h1:3'h5]})
		else $error("wake in s0");
	a_s5_pulse: assert property (o_s5_request |=> !o_s5_request) else $error("s5 not a pulse");
	a_s5_held: assert property (o_s5_request |-> s_long_hold) else $error("s5 too early");
	a_rsvd_zero: assert property (rd_done && i_address == 4'h0 |-> (o_readdata & ~32'h921) == 32'h0)
		else $error("reserved bits set");
	a_unmapped_zero: assert property (rd_done && i_address[1:0] != 2'h0 |-> o_readdata == 32'h0)
		else $error("unmapped read nonzero");
endmodule : pmevs_sva

// [sim/pmevs_button.sv]
// power button model: pin pulled high, low while held
module pmevs_button (
	input wire logic i_ref_clk, // clock
	input wire logic i_hold, // press command
	output logic o_power_button_in_n // pin, low = pressed
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_power_button_in_n = 1'b1;
	always @(posedge i_ref_clk) o_power_button_in_n <= !i_hold;
endmodule : pmevs_button

// [sim/pmevs_top_test.sv]
// testbench of the pm event status block
`include "pmevs_params.svh"
module pmevs_top_test import pmevs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] OVR = 32'd20;
	logic i_ref_clk = 1'b0, i_rst = 1'b1, i_hard_rst = 1'b0, hold = 1'b0;
	logic [2:0] sleep = 3'h0;
	pmevs_avreq_t rq = '0;
	logic [31:0] rd, seed = 32'h41388ed9, rdata;
	logic [3:0] lanes = 4'h3;
	logic wait_req, sci, smi_n, wake, s5, irq, pin_n;
	int n_errors = 0, cmp_count = 0, k;
	always #5 i_ref_clk = ~i_ref_clk;
	pmevs_button pmevs_button_i (.i_ref_clk(i_ref_clk), .i_hold(hold), .o_power_button_in_n(pin_n));
	pmevs_top #(.OVR_CYCLES(OVR)) pmevs_top_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hard_rst(i_hard_rst),
		.i_power_button_in_n(pin_n), .i_sleep_state(sleep), .i_address(rq.addr), .i_read(rq.read),
		.i_write(rq.write), .i_byteenable(rq.be), .i_writedata(rq.wdata), .o_readdata(rdata),
		.o_waitrequest(wait_req), .o_sci(sci), .o_system_mgmt_irq_n(smi_n), .o_wake(wake),
		.o_s5_request(s5), .o_irq(irq));
	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task cyc(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask : cyc
	task close_out;
		if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		rq <= '{read: !w, write: w, addr: a, be: lanes, wdata: d};
		do @(posedge i_ref_clk); while (wait_req !== 1'b0);
		rd = rdata;
		rq <= '0;
	endtask : bus
	task rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rchk
	task hard_reset;
		i_hard_rst <= 1'b1;
		cyc(1);
		i_hard_rst <= 1'b0;
	endtask : hard_reset
	initial begin
		cyc(4);
		i_rst <= 1'b0;
		rchk("status", `PMEVS_STS_OFS, 32'h0);
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			bus(1'b1, `PMEVS_EN_OFS, seed);
			rchk("enable", `PMEVS_EN_OFS, seed & 32'(`PMEVS_STS_MASK));
			lanes = {seed[31:30], ~seed[9], seed[9]};
			bus(1'b1, `PMEVS_EN_OFS, ~seed);
			lanes = 4'h3;
			rchk("enable lane", `PMEVS_EN_OFS, {16'h0000, (seed[9] ? {seed[15:8], ~seed[7:0]} :
				{~seed[15:8], seed[7:0]})} & 32'(`PMEVS_STS_MASK));
			bus(1'b1, `PMEVS_STS_OFS, seed);
			rchk("status", `PMEVS_STS_OFS, 32'h0);
			bus(1'b1, {seed[3:2], seed[1:0] | 2'h1}, seed);
			rchk("unmapped", {seed[3:2], seed[1:0] | 2'h1}, 32'h0);
		end
		bus(1'b1, `PMEVS_EN_OFS, 32'h0);
		hold <= 1'b1;
		cyc(3);
		hold <= 1'b0;
		rchk("status", `PMEVS_STS_OFS, 32'h100);
		bus(1'b1, `PMEVS_STS_OFS, 32'hfeff);
		rchk("status", `PMEVS_STS_OFS, 32'h100);
		hard_reset();
		rchk("status", `PMEVS_STS_OFS, 32'h100);
		bus(1'b1, `PMEVS_CTL_OFS, 32'h1);
		bus(1'b1, `PMEVS_EN_OFS, 32'h100);
		cyc(3);
		chk("sci", 32'h1, 32'(sci));
		chk("irq", 32'h1, 32'(irq));
		bus(1'b1, `PMEVS_CTL_OFS, 32'h0);
		cyc(3);
		chk("smi_n", 32'h0, 32'(smi_n));
		seed = xs(seed);
		sleep <= 3'h1 + 3'(seed[7:0] % 8'd5);
		cyc(3);
		chk("wake", 32'h1, 32'(wake));
		chk("smi_n", 32'h1, 32'(smi_n));
		sleep <= 3'h0;
		bus(1'b1, `PMEVS_STS_OFS, 32'h100);
		rchk("status", `PMEVS_STS_OFS, 32'h0);
		cyc(3);
		chk("irq", 32'h0, 32'(irq));
		bus(1'b1, `PMEVS_CTL_OFS, 32'h5);
		rchk("status", `PMEVS_STS_OFS, 32'h20);
		chk("sci", 32'h1, 32'(sci));
		bus(1'b1, `PMEVS_STS_OFS, 32'h20);
		rchk("status", `PMEVS_STS_OFS, 32'h0);
		bus(1'b1, `PMEVS_CTL_OFS, 32'h0);
		hold <= 1'b1;
		for (k = 0; k < 100 && s5 !== 1'b1; k++) cyc(1);
		chk("s5 delay ok", 32'h1, 32'(k >= OVR && k < OVR + 8));
		hold <= 1'b0;
		rchk("status", `PMEVS_STS_OFS, 32'h800);
		rchk("enable", `PMEVS_EN_OFS, 32'h100);
		hard_reset();
		rchk("timer", `PMEVS_TMR_OFS, 32'h0);
		cyc(80);
		// read taken 85 cycles after the hard reset, just past three divider periods of 28
		rchk("timer", `PMEVS_TMR_OFS, 32'h3);
		rchk("status", `PMEVS_STS_OFS, 32'h800);
		bus(1'b1, `PMEVS_STS_OFS, 32'h800);
		rchk("status", `PMEVS_STS_OFS, 32'h0);
		close_out();
	end
	initial begin
		cyc(20000);
		n_errors++;
		close_out();
	end
endmodule : pmevs_top_test
bind pmevs_top pmevs_sva #(.OVR_CYCLES(OVR_CYCLES)) pmevs_sva_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_power_button_in_n(i_power_button_in_n), .i_sleep_state(i_sleep_state), .i_address(i_address),
	.i_read(i_read), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_sci(o_sci),
	.o_system_mgmt_irq_n(o_system_mgmt_irq_n), .o_wake(o_wake), .o_s5_request(o_s5_request));
